// ### inc/adc_ctrl_pkg.sv
// constants, register map and types for the reference, clock and rate control
package adc_ctrl_pkg;

	localparam logic [7:0]  ADDR_STATUS     = 8'h01;
	localparam logic [7:0]  ADDR_DATA_RATE  = 8'h04;
	localparam logic [7:0]  ADDR_REF_CTRL   = 8'h05;
	localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h11;

	localparam int unsigned RATE_CODE_LSB   = 0;
	localparam int unsigned RATE_FILTER_BIT = 4;
	localparam int unsigned RATE_CLKSEL_BIT = 6;
	localparam int unsigned REF_CON_LSB     = 0;
	localparam int unsigned REF_SEL_LSB     = 2;
	localparam int unsigned REF_NBUF_BIT    = 4;
	localparam int unsigned REF_PBUF_BIT    = 5;

	localparam int unsigned ST_LOW0_BIT     = 0;
	localparam int unsigned ST_LOW1_BIT     = 1;
	localparam int unsigned ST_SETTLED_BIT  = 2;
	localparam int unsigned ST_BUSY_BIT     = 3;

	localparam int unsigned IRQ_CONV_BIT    = 0;
	localparam int unsigned IRQ_LOW0_BIT    = 1;
	localparam int unsigned IRQ_LOW1_BIT    = 2;
	localparam int unsigned IRQ_SETTLE_BIT  = 3;

	localparam logic [7:0]  DATA_RATE_RST   = 8'h14;
	localparam logic [7:0]  REF_CTRL_RST    = 8'h00;
	localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

	localparam logic [1:0]  REF_SRC_EXT0    = 2'h0;
	localparam logic [1:0]  REF_SRC_EXT1    = 2'h1;
	localparam logic [1:0]  REF_SRC_INT     = 2'h2;
	localparam logic [1:0]  REF_PWR_OFF     = 2'h0;
	localparam logic [1:0]  REF_PWR_ON_PD   = 2'h1;
	localparam logic [1:0]  REF_PWR_ON      = 2'h2;

	localparam logic [3:0]  MOD_DIV_LAST    = 4'hF;

	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned REF_SETTLE_NS   = 4500000;
	localparam int unsigned REF_SETTLE_CYC  =
		(REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [16:0] OSR_TABLE [16] = '{
		17'h19000, 17'h0C800, 17'h06400, 17'h03C00,
		17'h03200, 17'h01400, 17'h010A8, 17'h00A00,
		17'h00500, 17'h00280, 17'h00140, 17'h00100,
		17'h00080, 17'h00040, 17'h00040, 17'h00040
	};

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN  = 2'b01,
		CONV_DONE = 2'b11
	} conv_state_t;

endpackage

// ### hw/mod_clock_divider.sv
// divides the selected system clock tick stream by sixteen
`timescale 1ns/10ps
module mod_clock_divider
	import adc_ctrl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	input  wire logic src_tick_i,
	output logic      mod_tick_o
);

	logic [3:0] div_q;
	logic       tick_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_q  <= 4'h0;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			tick_q <= src_tick_i && (div_q == MOD_DIV_LAST);
			if (src_tick_i) begin
				div_q <= div_q + 4'h1;
			end
		end
	end

	assign mod_tick_o = tick_q;

endmodule

// ### hw/conversion_timer.sv
// counts modulator ticks per output word from the rate code
`timescale 1ns/10ps
module conversion_timer
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic        run_i,
	input  wire logic        restart_i,
	input  wire logic        mod_tick_i,
	input  wire logic [3:0]  rate_code_i,
	output logic [16:0]      osr_o,
	output logic             conv_done_o,
	output logic             busy_o
);

	conv_state_t state_q;
	logic [16:0] cnt_q;
	logic [16:0] osr_q;
	wire  [16:0] osr_sel = OSR_TABLE[rate_code_i];
	wire         last    = mod_tick_i && (cnt_q == osr_q - 17'h00001);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= CONV_IDLE;
			cnt_q   <= 17'h00000;
			osr_q   <= 17'h00040;
		end else if (ce_i) begin
			case (state_q)
				CONV_IDLE: begin
					cnt_q <= 17'h00000;
					osr_q <= osr_sel;
					// a rate write here is reloaded by one more idle cycle
					if (run_i && !restart_i) begin
						state_q <= CONV_RUN;
					end
				end
				CONV_RUN: begin
					if (!run_i || restart_i) begin
						state_q <= CONV_IDLE;
					end else if (last) begin
						state_q <= CONV_DONE;
					end else if (mod_tick_i) begin
						cnt_q <= cnt_q + 17'h00001;
					end
				end
				CONV_DONE: begin
					cnt_q   <= 17'h00000;
					osr_q   <= osr_sel;
					state_q <= (run_i && !restart_i) ? CONV_RUN : CONV_IDLE;
				end
				default: begin
					state_q <= CONV_IDLE;
				end
			endcase
		end
	end

	assign osr_o       = osr_q;
	assign conv_done_o = (state_q == CONV_DONE);
	assign busy_o      = (state_q == CONV_RUN);

endmodule

// ### hw/adc_ref_clk_rate_ctrl.sv
// reference, clock source, filter and data-rate control with reference monitor
//
// Contract
// - reference source is internal or one of two external pairs, by 2-bit select.
// - after reset the select chooses external reference pair 0.
// - select value binary 10 routes the internal reference to conversions.
// - power field 10 keeps reference on; 01 on except in power-down.
// - after reset the internal reference is powered down.
// - buffer control bits are active low: 1 disables, 0 enables.
// - low or missing reference is checked each conversion, two status flags.
// - clock-select bit chooses internal oscillator or external clock input.
// - any reset, pin or command, returns clock source to internal oscillator.
// - modulator clock is the system clock divided by sixteen.
// - filter-type bit selects sinc or low-latency decimation filter.
// - modulator clocks per word are the same for both filter types.
// - codes 0000 to 0110 give ratios 102400 down to 4264.
// - codes 0111 to 1101 give ratios 2560 down to 64.
// - filter bit 0 selects low-latency filter, 1 selects sinc.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module adc_ref_clk_rate_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned REF_SETTLE_CYCLES = REF_SETTLE_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic        reset_cmd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        int_osc_tick_i,
	input  wire logic        ext_clk_i,
	input  wire logic        ref_low_cmp0_i,
	input  wire logic        ref_low_cmp1_i,
	input  wire logic        power_down_i,
	output logic      [1:0]  reference_source_select_o,
	output logic             internal_ref_enable_o,
	output logic             positive_ref_buffer_disable_n_o,
	output logic             negative_ref_buffer_disable_n_o,
	output logic             low_latency_filter_o,
	output logic             ext_clock_select_o,
	output logic             mod_tick_o,
	output logic             conv_done_o,
	output logic      [16:0] osr_o,
	output logic             ref_low_flag_0_o,
	output logic             ref_low_flag_1_o,
	output logic             ref_settled_o,
	output logic             irq_o
);

	// pin reset and reset command act alike except on the pin synchronisers and the external clock edge register
	wire srst = !rst_b_i || reset_cmd_i;

	// two-stage synchronisers for the asynchronous pins
	wire  [2:0] pin_raw = {ref_low_cmp1_i, ref_low_cmp0_i, ext_clk_i};
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (!rst_b_i) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
				end else if (ce_i) begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate

	wire ext_clk_s  = pin_s2_q[0];
	wire ref_low0_s = pin_s2_q[1];
	wire ref_low1_s = pin_s2_q[2];

	logic ext_clk_d1_q;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ext_clk_d1_q <= 1'b0;
		end else if (ce_i) begin
			ext_clk_d1_q <= ext_clk_s;
		end
	end

	wire ext_clk_rise = ext_clk_s && !ext_clk_d1_q;

	// register file
	logic [7:0] data_rate_q;
	logic [7:0] ref_ctrl_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_stat_q;
	logic [7:0] rdata_q;

	wire sel_status = (reg_addr_i == ADDR_STATUS);
	wire sel_rate   = (reg_addr_i == ADDR_DATA_RATE);
	wire sel_ref    = (reg_addr_i == ADDR_REF_CTRL);
	wire sel_istat  = (reg_addr_i == ADDR_IRQ_STATUS);
	wire sel_imask  = (reg_addr_i == ADDR_IRQ_MASK);

	wire wr_rate    = reg_wr_i && sel_rate;
	wire wr_ref     = reg_wr_i && sel_ref;
	wire wr_imask   = reg_wr_i && sel_imask;
	wire rd_istat   = reg_rd_i && sel_istat;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			data_rate_q <= DATA_RATE_RST;
			ref_ctrl_q  <= REF_CTRL_RST;
			irq_mask_q  <= IRQ_MASK_RST;
		end else if (ce_i) begin
			if (wr_rate) begin
				data_rate_q <= reg_wdata_i;
			end
			if (wr_ref) begin
				ref_ctrl_q <= reg_wdata_i;
			end
			if (wr_imask) begin
				irq_mask_q <= reg_wdata_i[3:0];
			end
		end
	end

	// field decode
	wire [3:0] rate_code  = data_rate_q[RATE_CODE_LSB +: 4];
	wire       filter_bit = data_rate_q[RATE_FILTER_BIT];
	wire       clk_sel    = data_rate_q[RATE_CLKSEL_BIT];
	wire [1:0] ref_con    = ref_ctrl_q[REF_CON_LSB +: 2];
	wire [1:0] ref_sel    = ref_ctrl_q[REF_SEL_LSB +: 2];
	wire       nbuf_bit   = ref_ctrl_q[REF_NBUF_BIT];
	wire       pbuf_bit   = ref_ctrl_q[REF_PBUF_BIT];

	// internal reference power, honouring power-down for the 01 setting
	wire ref_on_d = (ref_con == REF_PWR_ON) ||
		((ref_con == REF_PWR_ON_PD) && !power_down_i);

	logic       ref_on_q;
	logic [1:0] ref_sel_q;
	logic       pbuf_q;
	logic       nbuf_q;
	logic       ll_filter_q;
	logic       ext_sel_q;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			ref_on_q    <= 1'b0;
			ref_sel_q   <= REF_SRC_EXT0;
			pbuf_q      <= REF_CTRL_RST[REF_PBUF_BIT];
			nbuf_q      <= REF_CTRL_RST[REF_NBUF_BIT];
			ll_filter_q <= !DATA_RATE_RST[RATE_FILTER_BIT];
			ext_sel_q   <= 1'b0;
		end else if (ce_i) begin
			ref_on_q    <= ref_on_d;
			ref_sel_q   <= ref_sel;
			pbuf_q      <= pbuf_bit;
			nbuf_q      <= nbuf_bit;
			ll_filter_q <= !filter_bit;
			ext_sel_q   <= clk_sel;
		end
	end

	// system clock source selection feeding the modulator divider
	wire src_tick = ext_sel_q ? ext_clk_rise : int_osc_tick_i;
	wire mod_tick;

	mod_clock_divider u_div (
		.clk_i      (clk_i),
		.srst_i     (srst),
		.ce_i       (ce_i),
		.src_tick_i (src_tick),
		.mod_tick_o (mod_tick)
	);

	// conversions run while the device is not powered down
	wire        conv_done;
	wire        conv_busy;
	wire [16:0] osr;

	conversion_timer u_conv (
		.clk_i       (clk_i),
		.srst_i      (srst),
		.ce_i        (ce_i),
		.run_i       (!power_down_i),
		.restart_i   (wr_rate),
		.mod_tick_i  (mod_tick),
		.rate_code_i (rate_code),
		.osr_o       (osr),
		.conv_done_o (conv_done),
		.busy_o      (conv_busy)
	);

	// reference monitor: any low sample within a conversion sets its flag
	logic [1:0] low_seen_q;
	logic [1:0] ref_flag_q;
	wire  [1:0] low_now  = {ref_low1_s, ref_low0_s};
	wire  [1:0] low_acc  = low_seen_q | (conv_busy ? low_now : 2'b00);

	always_ff @(posedge clk_i) begin
		if (srst) begin
			low_seen_q <= 2'b00;
			ref_flag_q <= 2'b00;
		end else if (ce_i) begin
			if (conv_done) begin
				ref_flag_q <= low_acc;
				low_seen_q <= 2'b00;
			end else begin
				low_seen_q <= low_acc;
			end
		end
	end

	// internal reference start-up timer
	logic [18:0] settle_cnt_q;
	logic        settled_q;
	wire         settle_hit =
		(settle_cnt_q == 19'(REF_SETTLE_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (srst) begin
			settle_cnt_q <= 19'h00000;
			settled_q    <= 1'b0;
		end else if (ce_i) begin
			if (!ref_on_q) begin
				settle_cnt_q <= 19'h00000;
				settled_q    <= 1'b0;
			end else if (!settled_q) begin
				settle_cnt_q <= settle_cnt_q + 19'h00001;
				settled_q    <= settle_hit;
			end
		end
	end

	// interrupt events, sticky until the interrupt status register is read
	logic       settled_d1_q;
	logic [1:0] ref_flag_d1_q;
	wire        settle_rise = settled_q && !settled_d1_q;
	wire  [1:0] flag_rise   = ref_flag_q & ~ref_flag_d1_q;
	wire  [3:0] irq_event   = {settle_rise, flag_rise[1], flag_rise[0], conv_done};

	always_ff @(posedge clk_i) begin
		if (srst) begin
			settled_d1_q  <= 1'b0;
			ref_flag_d1_q <= 2'b00;
			irq_stat_q    <= 4'h0;
		end else if (ce_i) begin
			settled_d1_q  <= settled_q;
			ref_flag_d1_q <= ref_flag_q;
			// a new event in the clearing cycle survives
			irq_stat_q    <= (rd_istat ? 4'h0 : irq_stat_q) | irq_event;
		end
	end

	logic irq_q;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else if (ce_i) begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// read path: data valid only in the cycle after the strobe
	wire [7:0] status_val = {4'h0, conv_busy, settled_q, ref_flag_q};
	wire [7:0] rd_mux =
		sel_status ? status_val :
		sel_rate   ? data_rate_q :
		sel_ref    ? ref_ctrl_q :
		sel_istat  ? {4'h0, irq_stat_q} :
		sel_imask  ? {4'h0, irq_mask_q} :
		8'h00;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (ce_i) begin
			rdata_q <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	logic       mod_tick_q;
	logic       conv_done_q;
	logic [16:0] osr_q;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			mod_tick_q  <= 1'b0;
			conv_done_q <= 1'b0;
			osr_q       <= 17'h00000;
		end else if (ce_i) begin
			mod_tick_q  <= mod_tick;
			conv_done_q <= conv_done;
			osr_q       <= osr;
		end
	end

	assign reg_rdata_o                     = rdata_q;
	assign reference_source_select_o       = ref_sel_q;
	assign internal_ref_enable_o           = ref_on_q;
	assign positive_ref_buffer_disable_n_o = pbuf_q;
	assign negative_ref_buffer_disable_n_o = nbuf_q;
	assign low_latency_filter_o            = ll_filter_q;
	assign ext_clock_select_o              = ext_sel_q;
	assign mod_tick_o                      = mod_tick_q;
	assign conv_done_o                     = conv_done_q;
	assign osr_o                           = osr_q;
	assign ref_low_flag_0_o                = ref_flag_q[0];
	assign ref_low_flag_1_o                = ref_flag_q[1];
	assign ref_settled_o                   = settled_q;
	assign irq_o                           = irq_q;

endmodule

// ### sim/ctrl_checker_assertions.sv
// assertions on the control outputs of the reference, clock and rate block
`timescale 1ns/10ps
module ctrl_checker
	import adc_ctrl_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       reset_cmd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [1:0] reference_source_select_o,
	input wire logic       internal_ref_enable_o,
	input wire logic       positive_ref_buffer_disable_n_o,
	input wire logic       negative_ref_buffer_disable_n_o,
	input wire logic       low_latency_filter_o,
	input wire logic       ext_clock_select_o,
	input wire logic       mod_tick_o,
	input wire logic       conv_done_o,
	input wire logic       ref_low_flag_0_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire wr_ref  = reg_wr_i && reg_addr_i == ADDR_REF_CTRL && !reset_cmd_i;
	wire wr_rate = reg_wr_i && reg_addr_i == ADDR_DATA_RATE && !reset_cmd_i;

	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	ref_select_a: assert property (wr_ref |-> ##2
		reference_source_select_o == $past(reg_wdata_i[3:2], 2)) else $error("ref select");
	buffer_bits_a: assert property (wr_ref |-> ##2
		{positive_ref_buffer_disable_n_o, negative_ref_buffer_disable_n_o}
		== $past(reg_wdata_i[5:4], 2)) else $error("buffer bits");
	ref_power_a: assert property (wr_ref && reg_wdata_i[1:0] != REF_PWR_ON_PD |-> ##2
		internal_ref_enable_o == ($past(reg_wdata_i[1:0], 2) == REF_PWR_ON))
		else $error("ref power");
	rate_fields_a: assert property (wr_rate |-> ##2
		ext_clock_select_o == $past(reg_wdata_i[6], 2)
		&& low_latency_filter_o == !$past(reg_wdata_i[4], 2)) else $error("rate fields");
	cmd_reset_a: assert property (reset_cmd_i |-> ##2
		!ext_clock_select_o && reference_source_select_o == REF_SRC_EXT0)
		else $error("reset command");
	mod_gap_a: assert property (mod_tick_o |=> !mod_tick_o [*8])
		else $error("modulator tick too early");
	flag_hold_a: assert property (!conv_done_o && !$past(reset_cmd_i) |->
		$stable(ref_low_flag_0_o)) else $error("flag moved between words");
endmodule

bind adc_ref_clk_rate_ctrl ctrl_checker ctrl_checker_inst (.*);

// ### sim/clk_source_model.sv
// clock sources beside the block: oscillator ticks and a free external clock
`timescale 1ns/10ps
module clk_source_model #(
	parameter int unsigned OSC_DIV     = 2,
	parameter int unsigned EXT_HALF_NS = 35
)
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	output logic      osc_tick_o,
	output logic      ext_clk_o
);
	logic [7:0] div_q;
	wire        last = div_q == 8'(OSC_DIV - 1);
	always_ff @(posedge clk_i) begin
		div_q <= (!rst_b_i || last) ? 8'h00 : div_q + 8'h01;
		osc_tick_o <= rst_b_i && last;
	end
	initial ext_clk_o = 1'b0;
	always #(EXT_HALF_NS) ext_clk_o = ~ext_clk_o;
endmodule

// ### sim/tb.sv
// self-checking bench for the reference, clock and rate control
`timescale 1ns/10ps
module tb;
	import adc_ctrl_pkg::*;
	logic        clk_i          = 1'b0;
	logic        rst_b_i        = 1'b0;
	logic        reset_cmd_i    = 1'b0;
	logic [7:0]  reg_addr_i     = 8'h00;
	logic [7:0]  reg_wdata_i    = 8'h00;
	logic        reg_wr_i       = 1'b0;
	logic        reg_rd_i       = 1'b0;
	logic        power_down_i   = 1'b0;
	logic        ce_i           = 1'b1;
	logic        ref_low_cmp0_i = 1'b0;
	logic        ref_low_cmp1_i = 1'b0;
	logic [7:0]  reg_rdata_o;
	logic [7:0]  d;
	logic [7:0]  v;
	logic [1:0]  reference_source_select_o;
	logic [16:0] osr_o;
	logic        int_osc_tick_i, ext_clk_i, internal_ref_enable_o, low_latency_filter_o;
	logic        positive_ref_buffer_disable_n_o, negative_ref_buffer_disable_n_o;
	logic        ext_clock_select_o, mod_tick_o, conv_done_o, ref_settled_o, irq_o;
	logic        ref_low_flag_0_o, ref_low_flag_1_o;
	int          errors = 0;
	int          comparisons = 0;
	int          n;
	int          m;
	int          osr_exp [14] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264,
		2560, 1280, 640, 320, 256, 128, 64};

	always #5 clk_i = ~clk_i;

	adc_ref_clk_rate_ctrl #(.REF_SETTLE_CYCLES(20)) adc_ref_clk_rate_ctrl_inst (.*);
	clk_source_model clk_source_model_inst (.clk_i, .rst_b_i, .osc_tick_o(int_osc_tick_i),
		.ext_clk_o(ext_clk_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s", $time, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= w;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 r = reg_rdata_o;
	endtask
	task automatic gap(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic wait_done(output int c, output int t);
		c = 0;
		t = 0;
		do begin
			@(negedge clk_i);
			c++;
			t += (mod_tick_o === 1'b1);
		end while (conv_done_o !== 1'b1 && c < 30000);
		if (c >= 30000) begin
			errors++;
			$display("MISMATCH %0t conversion never ended", $time);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#300000;
		errors++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(ADDR_DATA_RATE, d);
		chk(d, DATA_RATE_RST, "rate reset value");
		rd(ADDR_REF_CTRL, d);
		chk(d, REF_CTRL_RST, "ref reset value");
		chk({reference_source_select_o, internal_ref_enable_o, ext_clock_select_o}, 0,
			"reset outputs");
		rd(8'h7F, d);
		chk(d, 0, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			// buffers off whenever the internal source is chosen
			v = {2'b00, 2'(i ^ 1), 2'(i % 3), (i == 3) ? REF_PWR_OFF : REF_PWR_ON};
			wr(ADDR_REF_CTRL, v);
			gap(2);
			chk({reference_source_select_o, positive_ref_buffer_disable_n_o,
				negative_ref_buffer_disable_n_o, internal_ref_enable_o},
				{v[3:2], v[5:4], v[1:0] == REF_PWR_ON}, "ref ctrl outputs");
		end
		wr(ADDR_REF_CTRL, {6'h00, REF_PWR_ON_PD});
		power_down_i <= 1'b1;
		gap(4);
		chk(internal_ref_enable_o, 0, "ref on in power-down");
		wr(ADDR_REF_CTRL, {6'h00, REF_PWR_ON});
		gap(2);
		chk(internal_ref_enable_o, 1, "always-on ref off in power-down");
		wr(ADDR_REF_CTRL, {6'h00, REF_PWR_ON_PD});
		@(posedge clk_i);
		power_down_i <= 1'b0;
		gap(4);
		chk(internal_ref_enable_o, 1, "ref off after power-down");
		rd(ADDR_STATUS, d);
		chk(d[ST_SETTLED_BIT], 0, "settled too early");
		gap(25);
		rd(ADDR_STATUS, d);
		chk({d[ST_SETTLED_BIT], ref_settled_o}, 2'b11, "not settled");
		$display("test reference done");
		// reserved rate codes are never written
		for (int i = 0; i < 28; i++) begin
			wr(ADDR_DATA_RATE, {3'b000, 1'(i / 14), 4'(i % 14)});
			gap(4);
			chk(osr_o, osr_exp[i % 14], "oversampling ratio");
			chk(low_latency_filter_o, 1'(i < 14), "filter select");
		end
		$display("test rates done");
		wr(ADDR_IRQ_MASK, 8'h02);
		wr(ADDR_DATA_RATE, 8'h0D);
		wait_done(n, m);
		@(posedge clk_i);
		ref_low_cmp0_i <= 1'b1;
		wait_done(n, m);
		chk(n, 64 * 16 * 2, "word period");
		chk(m, 64, "ticks per word");
		chk({ref_low_flag_1_o, ref_low_flag_0_o}, 2'b01, "flag 0");
		gap(3);
		chk(irq_o, 1, "irq not raised");
		@(posedge clk_i);
		ref_low_cmp0_i <= 1'b0;
		ref_low_cmp1_i <= 1'b1;
		rd(ADDR_IRQ_STATUS, d);
		chk(d[IRQ_LOW0_BIT], 1, "irq status bit");
		gap(3);
		chk(irq_o, 0, "irq not cleared");
		// the word in flight already saw the first comparator low
		wait_done(n, m);
		chk({ref_low_flag_1_o, ref_low_flag_0_o}, 2'b11, "flags overlap");
		wait_done(n, m);
		chk({ref_low_flag_1_o, ref_low_flag_0_o}, 2'b10, "flag 1");
		gap(3);
		chk(irq_o, 0, "masked irq raised");
		@(posedge clk_i);
		ref_low_cmp1_i <= 1'b0;
		ce_i <= 1'b0;
		wr(ADDR_IRQ_MASK, 8'h0F);
		ce_i <= 1'b1;
		rd(ADDR_IRQ_MASK, d);
		chk(d, 8'h02, "write while frozen");
		$display("test conversion done");
		wr(ADDR_DATA_RATE, 8'h4D);
		gap(2);
		chk(ext_clock_select_o, 1, "ext clock select");
		// first interval after the switch may be partial
		repeat (3) begin
			n = 0;
			do begin
				@(negedge clk_i);
				n++;
			end while (mod_tick_o !== 1'b1 && n < 500);
		end
		chk(n inside {[110:114]}, 1, "ext modulator period");
		@(posedge clk_i);
		reset_cmd_i <= 1'b1;
		@(posedge clk_i);
		reset_cmd_i <= 1'b0;
		gap(3);
		chk(ext_clock_select_o, 0, "clock after command");
		rd(ADDR_DATA_RATE, d);
		chk(d, DATA_RATE_RST, "rate after command");
		$display("test clock done");
		wrap_up();
	end
endmodule
